// ---- design/stcc_pkg.sv ----
// Package: offsets, fields, reset values and decode for the sync/tx/clkout register bank.
// Assumes AHB-Lite word access; each 8-bit register sits in the low byte of one word.
package stcc_pkg;

  localparam int unsigned REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SYNC_B0  = 6'h16;
  localparam logic [5:0] IDX_SYNC_B1  = 6'h17;
  localparam logic [5:0] IDX_SYNC_B2  = 6'h18;
  localparam logic [5:0] IDX_SYNC_B3  = 6'h19;
  localparam logic [5:0] IDX_TX_PARAM = 6'h1A;
  localparam logic [5:0] IDX_CLK_OUT  = 6'h1B;

  localparam logic [7:0] RST_SYNC = 8'h00;
  localparam logic [7:0] RST_TX   = 8'h7C;
  localparam logic [7:0] RST_CLK  = 8'hBC;

  // Writable bits; reserved bits are stored as zero
  localparam logic [7:0] MASK_TX  = 8'hFE;
  localparam logic [7:0] MASK_CLK = 8'hFC;

  localparam int unsigned TX_CUT_LSB  = 4;
  localparam int unsigned TX_CUT_W    = 4;
  localparam int unsigned TX_PWR_LSB  = 1;
  localparam int unsigned TX_PWR_W    = 3;
  localparam int unsigned CLK_EN_BIT  = 7;
  localparam int unsigned CLK_DIV_LSB = 2;
  localparam int unsigned CLK_DIV_W   = 5;

  localparam logic       HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    SLOT_SYNC0, SLOT_SYNC1, SLOT_SYNC2, SLOT_SYNC3, SLOT_TX, SLOT_CLK, SLOT_NONE
  } stcc_slot_t;

  function automatic stcc_slot_t stcc_decode(input logic [31:0] addr);
    stcc_slot_t s;
    s = SLOT_NONE;
    if (addr[31:8] == 24'h000000 && addr[1:0] == 2'h0) begin
      case (addr[7:2])
        IDX_SYNC_B0:  s = SLOT_SYNC0;
        IDX_SYNC_B1:  s = SLOT_SYNC1;
        IDX_SYNC_B2:  s = SLOT_SYNC2;
        IDX_SYNC_B3:  s = SLOT_SYNC3;
        IDX_TX_PARAM: s = SLOT_TX;
        IDX_CLK_OUT:  s = SLOT_CLK;
        default:      s = SLOT_NONE;
      endcase
    end
    return s;
  endfunction

endpackage

// ---- design/stcc_div_if.sv ----
// Interface: divider setting and gate from the register bank, gated clock back.
// Assumes one driver per signal: core drives the settings, the divider the clock.
`timescale 1ns/100ps
interface stcc_div_if;
  logic [4:0] divider;
  logic       enable;
  logic       clk_q;

  modport core (output divider, output enable, input clk_q);
  modport div  (input divider, input enable, output clk_q);
endinterface

// ---- design/stcc_clkdiv.sv ----
// Clock output divider with glitch-free gate.
// Assumes xtal_clk is asynchronous and well below half the hclk rate.
`timescale 1ns/100ps
module stcc_clkdiv
  import stcc_pkg::*;
#(
  parameter int unsigned DIV_W = CLK_DIV_W
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  xtal_clk,
  stcc_div_if.div    dif
);

  logic             sync1;
  logic             sync2;
  logic             sync3;
  logic [DIV_W-1:0] cnt;
  logic             div_raw;
  logic             en_eff;
  logic             xtal_rise;
  logic             div_zero;
  logic             cnt_wrap;

  assign xtal_rise = sync2 & ~sync3;
  assign div_zero  = (dif.divider == '0);
  // Greater-or-equal so a divider lowered mid-count still wraps
  assign cnt_wrap  = (cnt >= DIV_W'(dif.divider - 5'h01));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= xtal_clk;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt     <= '0;
      div_raw <= 1'b0;
    end else if (div_zero) begin
      cnt     <= '0;
      div_raw <= sync2; // RULE_08
    end else if (xtal_rise) begin
      if (cnt_wrap) begin
        cnt     <= '0;
        div_raw <= ~div_raw; // RULE_09
      end else begin
        cnt <= cnt + DIV_W'(1);
      end
    end
  end

  // Gate only moves while the raw clock is low, so no runt pulse leaves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_eff    <= 1'b0;
      dif.clk_q <= 1'b0;
    end else begin
      if (!div_raw) begin
        en_eff <= dif.enable; // RULE_12
      end
      dif.clk_q <= div_raw & en_eff; // RULE_07
    end
  end

  a_undiv_follow: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    div_zero |=> div_raw == $past(sync2))
    else $error("undivided clock does not follow crystal");

  a_div_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    (!div_zero && xtal_rise && cnt_wrap) |=> div_raw != $past(div_raw))
    else $error("divided clock missed its toggle");

  a_div_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    (!div_zero && !xtal_rise) |=> $stable(div_raw))
    else $error("divided clock moved without crystal edge");

  a_gate_low: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
    $changed(en_eff) |-> $past(!div_raw))
    else $error("gate changed while clock high");

  a_gate_off: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
    (!en_eff)[*2] |-> !dif.clk_q)
    else $error("clock output not held low while gated");

endmodule

// ---- design/stcc_regs.sv ----
// Sync pattern, transmit parameter and clock output registers behind an AHB-Lite slave.
// Assumes single word transfers; hreadyout is always high, so no wait states occur.
//
// What this block does
// RULE_01: Bits 23..16 of the sync pattern live in a read/write register at index 0x17, reset 0.
// RULE_02: Bits 15..8 of the sync pattern live in a read/write register at index 0x18, reset 0.
// RULE_03: Bits 7..0 of the sync pattern live in a read/write register at index 0x19, reset 0.
// RULE_04: Transmit parameter bits 7..4 set the interpolation cutoff field, reset 0111.
// RULE_05: Transmit parameter bits 3..1 pick output power in 3 dB steps, reset code 110.
// RULE_06: Software keeps transmit parameter bit 0 at zero; it is reserved.
// RULE_07: Clock output control bit 7 gates the clock output pin, reset one.
// RULE_08: A divider field of zero puts the undivided crystal clock on the clock output.
// RULE_09: A nonzero divider field N gives the crystal clock divided by 2N, reset 01111.
// RULE_10: Software keeps clock output control bits 1..0 at zero; they are reserved.
// RULE_11: Bits 31..24 of the sync pattern live in a read/write register at index 0x16, reset 0.
// RULE_12: A disabled clock output sits low and gating it never makes a glitch.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module stcc_regs
  import stcc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        xtal_clk,
  output logic [31:0]      sync_pattern_value,
  output logic [3:0]       tx_interp_cutoff,
  output logic [2:0]       tx_power_level,
  output logic             clk_out_enable,
  output logic [4:0]       clk_out_divider,
  output logic             clk_out
);

  logic [REG_W-1:0] sync_reg  [4];
  logic [REG_W-1:0] next_sync [4];
  logic [REG_W-1:0] tx_reg;
  logic [REG_W-1:0] clk_reg;
  logic [REG_W-1:0] next_tx;
  logic [REG_W-1:0] next_clk;
  logic [REG_W-1:0] rd_val;
  logic             accept;
  logic             wr_pend;
  stcc_slot_t       wr_slot;
  stcc_slot_t       a_slot;
  logic [2:0]       a_code;
  logic             wr_tx;
  logic             wr_clk;
  logic [2:0]       unused_hsize;

  stcc_div_if dif ();

  // Only whole words are expected; size is not checked
  assign unused_hsize = hsize;

  // Address phase decode
  assign accept = hsel & hready & htrans[1];
  assign a_slot = stcc_decode(haddr);
  assign a_code = a_slot;

  // Data phase write strobes
  assign wr_tx  = wr_pend && (wr_slot == SLOT_TX);
  assign wr_clk = wr_pend && (wr_slot == SLOT_CLK);

  // Reserved bits are dropped on write and read back as zero
  assign next_tx  = wr_tx  ? (hwdata[7:0] & MASK_TX)  : tx_reg;  // RULE_06
  assign next_clk = wr_clk ? (hwdata[7:0] & MASK_CLK) : clk_reg; // RULE_10

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      assign next_sync[gi] = (wr_pend && wr_slot == stcc_slot_t'(gi)) ? hwdata[7:0]
                                                                       : sync_reg[gi];

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_reg[gi] <= RST_SYNC;
        end else begin
          sync_reg[gi] <= next_sync[gi]; // RULE_11
        end
      end
    end
  endgenerate

  // Read from the next values so a read right behind a write sees the new data
  assign rd_val = (a_slot == SLOT_TX)   ? next_tx  :
                  (a_slot == SLOT_CLK)  ? next_clk :
                  (a_slot == SLOT_NONE) ? 8'h00    :
                  next_sync[a_code[1:0]];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_reg  <= RST_TX;
      clk_reg <= RST_CLK;
    end else begin
      tx_reg  <= next_tx;  // RULE_04
      clk_reg <= next_clk; // RULE_07
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_slot <= SLOT_NONE;
    end else begin
      wr_pend <= accept & hwrite;
      if (accept) begin
        wr_slot <= a_slot;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
      if (accept && !hwrite) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  // Sync byte at index 0x16 is the most significant
  assign sync_pattern_value = {sync_reg[0], sync_reg[1], sync_reg[2], sync_reg[3]}; // RULE_01
  assign tx_interp_cutoff   = tx_reg[TX_CUT_LSB +: TX_CUT_W];
  assign tx_power_level     = tx_reg[TX_PWR_LSB +: TX_PWR_W]; // RULE_05
  assign clk_out_enable     = clk_reg[CLK_EN_BIT];
  assign clk_out_divider    = clk_reg[CLK_DIV_LSB +: CLK_DIV_W];

  assign dif.divider = clk_out_divider; // RULE_09
  assign dif.enable  = clk_out_enable;
  assign clk_out     = dif.clk_q;

  stcc_clkdiv #(
    .DIV_W    (CLK_DIV_W)
  ) u_clkdiv (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .xtal_clk (xtal_clk),
    .dif      (dif)
  );

  a_reset_vals: assert property (@(posedge hclk) // RULE_04
    $rose(hresetn) |-> (sync_pattern_value == 32'h00000000) && (tx_reg == RST_TX)
                       && (clk_reg == RST_CLK))
    else $error("register bank left reset with wrong values");

  a_sync_top_wr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    (accept && hwrite && a_slot == SLOT_SYNC0) ##1 1'b1
      |=> sync_pattern_value[31:24] == $past(hwdata[7:0]))
    else $error("sync byte 31..24 not written");

  a_sync_b1_wr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (accept && hwrite && a_slot == SLOT_SYNC1) ##1 1'b1
      |=> sync_pattern_value[23:16] == $past(hwdata[7:0]))
    else $error("sync byte 23..16 not written");

  a_sync_b2_wr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    (accept && hwrite && a_slot == SLOT_SYNC2) ##1 1'b1
      |=> sync_pattern_value[15:8] == $past(hwdata[7:0]))
    else $error("sync byte 15..8 not written");

  a_sync_b3_wr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    (accept && hwrite && a_slot == SLOT_SYNC3) ##1 1'b1
      |=> sync_pattern_value[7:0] == $past(hwdata[7:0]))
    else $error("sync byte 7..0 not written");

  a_tx_fields_wr: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    (accept && hwrite && a_slot == SLOT_TX) ##1 1'b1
      |=> (tx_power_level == $past(hwdata[3:1])) && (tx_interp_cutoff == $past(hwdata[7:4]))
          && !tx_reg[0])
    else $error("transmit parameter fields not written");

  a_sync_stable: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    !wr_pend |=> $stable(sync_pattern_value))
    else $error("sync pattern changed without a write");

  a_clk_gate: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    $rose(clk_out) |-> $past(clk_out_enable, 2))
    else $error("clock output rose while gated off");

  a_read_back: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    (accept && !hwrite && a_slot == SLOT_TX && !wr_pend) |=> hrdata == {24'h000000, tx_reg})
    else $error("read of transmit parameters returned wrong data");

  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    (accept && !hwrite && a_slot == SLOT_NONE) |=> hrdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

  a_clk_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    wr_clk |=> clk_reg[1:0] == 2'h0 && clk_out_divider == $past(hwdata[6:2]))
    else $error("clock control write stored reserved bits");

  // Slave never stalls or errors, so the master never needs a retry path
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    hreadyout && (hresp == HRESP_OKAY))
    else $error("slave stalled or answered with an error");

  a_rd_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  a_rd_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    !(accept && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_sync_b0_read: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    (accept && !hwrite && a_slot == SLOT_SYNC0 && !wr_pend)
      |=> hrdata[7:0] == sync_pattern_value[31:24])
    else $error("read of sync byte 31..24 returned wrong data");

  a_tx_resv_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    !tx_reg[0])
    else $error("transmit parameter reserved bit set");

  a_clk_resv_low: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    clk_reg[1:0] == 2'h0)
    else $error("clock control reserved bits set");

  a_tx_stable: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    !wr_tx |=> $stable(tx_reg))
    else $error("transmit parameters changed without a write");

  a_clk_stable: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    !wr_clk |=> $stable(clk_reg))
    else $error("clock control changed without a write");

endmodule

// ---- sim/test_stcc_regs.sv ----
// Testbench for the sync pattern, transmit parameter and clock output register bank.
// Assumes the bench is the only AHB-Lite master and drives the crystal clock pin itself.
`timescale 1ns/100ps
module test_stcc_regs
  import stcc_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        xtal_clk;
  logic [31:0] sync_pattern_value;
  logic [3:0]  tx_interp_cutoff;
  logic [2:0]  tx_power_level;
  logic        clk_out_enable;
  logic [4:0]  clk_out_divider;
  logic        clk_out;
  int          fails;
  int          checks_done;

  stcc_regs stcc_regs_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xtal_clk(xtal_clk),
    .sync_pattern_value(sync_pattern_value), .tx_interp_cutoff(tx_interp_cutoff),
    .tx_power_level(tx_power_level), .clk_out_enable(clk_out_enable),
    .clk_out_divider(clk_out_divider), .clk_out(clk_out)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Crystal at 10 MHz, one crystal period is ten bus cycles; phase offset on purpose
  initial begin
    xtal_clk = 1'b0;
    #3;
    forever #50 xtal_clk = ~xtal_clk;
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [7:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, {24'h000000, idx, 2'h0}, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, addr, 8'h00, r);
    check(r, {24'h000000, exp});
  endtask

  // Counts bus cycles to the next rising edge of the clock output
  task automatic to_rise(output int n);
    logic p;
    n = 0;
    do begin
      p = clk_out;
      @(negedge hclk);
      n++;
    end while (!(p === 1'b0 && clk_out === 1'b1) && n < 2000);
    if (n >= 2000) begin
      fails++;
      finish_test();
    end
  endtask

  // Sampled replica, so one bus cycle of jitter is allowed
  task automatic period_chk(input int exp);
    int n;
    to_rise(n);
    to_rise(n);
    to_rise(n);
    check({31'h0, (n >= exp - 1 && n <= exp + 1)}, 32'h1);
  endtask

  task automatic reset_values();
    rd_chk({24'h0, IDX_SYNC_B0, 2'h0}, 8'h00);
    rd_chk({24'h0, IDX_SYNC_B1, 2'h0}, 8'h00);
    rd_chk({24'h0, IDX_SYNC_B2, 2'h0}, 8'h00);
    rd_chk({24'h0, IDX_SYNC_B3, 2'h0}, 8'h00);
    rd_chk({24'h0, IDX_TX_PARAM, 2'h0}, 8'h7C);
    rd_chk({24'h0, IDX_CLK_OUT, 2'h0}, 8'hBC);
    period_chk(2 * 15 * 10);
  endtask

  task automatic sync_bytes();
    wr(IDX_SYNC_B0, 8'hA1);
    wr(IDX_SYNC_B1, 8'h5C);
    wr(IDX_SYNC_B2, 8'h3E);
    wr(IDX_SYNC_B3, 8'hF0);
    @(negedge hclk);
    check(sync_pattern_value, 32'hA15C3EF0);
    rd_chk({24'h0, IDX_SYNC_B1, 2'h0}, 8'h5C);
    rd_chk({24'h0, IDX_SYNC_B2, 2'h0}, 8'h3E);
    rd_chk({24'h0, IDX_SYNC_B3, 2'h0}, 8'hF0);
  endtask

  task automatic tx_codes();
    logic [3:0] cut;
    for (int c = 0; c < 8; c++) begin
      cut = 4'(2 * c + 1);
      wr(IDX_TX_PARAM, {cut, 3'(c), 1'b0});
      @(negedge hclk);
      check({28'h0, tx_interp_cutoff}, {28'h0, cut});
      check({29'h0, tx_power_level}, 32'(c));
      rd_chk({24'h0, IDX_TX_PARAM, 2'h0}, {cut, 3'(c), 1'b0});
    end
  endtask

  task automatic unmapped();
    logic [31:0] r;
    bus(1'b1, 32'h00000070, 8'h55, r);
    rd_chk(32'h00000070, 8'h00);
    bus(1'b1, 32'h00000158, 8'h66, r);
    rd_chk(32'h00000158, 8'h00);
    rd_chk({24'h0, IDX_SYNC_B0, 2'h0}, 8'hA1);
  endtask

  task automatic clock_out();
    int div_tab[3] = '{2, 0, 5};
    int cnt;
    foreach (div_tab[i]) begin
      wr(IDX_CLK_OUT, {1'b1, 5'(div_tab[i]), 2'h0});
      @(negedge hclk);
      check({27'h0, clk_out_divider}, 32'(div_tab[i]));
      period_chk(div_tab[i] == 0 ? 10 : 2 * div_tab[i] * 10);
    end
    wr(IDX_CLK_OUT, 8'h04);
    @(negedge hclk);
    check({31'h0, clk_out_enable}, 32'h0);
    repeat (40) @(negedge hclk);
    cnt = 0;
    repeat (100) begin
      @(negedge hclk);
      if (clk_out !== 1'b0)
        cnt++;
    end
    check(32'(cnt), 32'h0);
    wr(IDX_CLK_OUT, 8'h84);
    period_chk(20);
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (15) @(posedge hclk);
    @(negedge hclk);
    check({31'h0, clk_out}, 32'h0);
    check({28'h0, tx_interp_cutoff}, 32'h7);
    check({29'h0, tx_power_level}, 32'h6);
    check({26'h0, clk_out_enable, clk_out_divider}, 32'h2F);
    @(posedge hclk);
    hresetn <= 1'b1;
    reset_values();
    sync_bytes();
    tx_codes();
    unmapped();
    clock_out();
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge hclk);
    fails++;
    finish_test();
  end
endmodule
